// *** hw/lookup_pkg.sv ***
package lookup_pkg;
   localparam int NPORT = 3;
   localparam int PW = 2;
   localparam int BUF_BYTES = 262144;
   localparam int FREE_W = 19;
   localparam int LEN_W = 14;
   localparam int FID_W = 7;
   localparam int IDX_W = 10;
   localparam int NBUCKET = 1024;
   localparam int NWAY = 4;
   localparam int NSTAT = 16;
   localparam int STAMP_W = 8;
   localparam logic [1:0] HASH_CRC = 2'h1;
   localparam logic [1:0] HASH_XOR = 2'h2;
   localparam logic [1:0] HASH_RST = 2'h1;
   localparam logic [15:0] CRC_POLY = 16'h1021;
   localparam logic [15:0] CRC_INIT = 16'h0000;
   localparam logic [6:0] FID_DEFAULT = 7'h00;
   localparam logic [39:0] RES_PREFIX = 40'h0180c20000;
   localparam logic [PW-1:0] MGMT_DFL_PORT = 2'h2;
   // register byte offsets
   localparam logic [7:0] OFS_CTRL0 = 8'h00;
   localparam logic [7:0] OFS_CTRL1 = 8'h04;
   localparam logic [7:0] OFS_SWMAC_LO = 8'h08;
   localparam logic [7:0] OFS_SWMAC_HI = 8'h0c;
   localparam logic [7:0] OFS_TMAC_LO = 8'h10;
   localparam logic [7:0] OFS_TMAC_HI = 8'h14;
   localparam logic [7:0] OFS_TATTR = 8'h18;
   localparam logic [7:0] OFS_TCMD = 8'h1c;
   localparam logic [7:0] OFS_STATUS = 8'h20;
   localparam logic [7:0] OFS_FULL = 8'h24;
   // field positions
   localparam int C0_VLAN = 0;
   localparam int C0_HASH = 1;
   localparam int C0_RESMC = 3;
   localparam int C1_SELF = 0;
   localparam int C1_TAIL = 4;
   localparam int TA_MASK = 0;
   localparam int TA_FID = 4;
   localparam int TA_VALID = 16;
   localparam int TA_SIDX = 20;
   localparam int CMD_STAT = 0;
   localparam int CMD_MAIN = 1;
   localparam int FULL_FLAG = 16;

   typedef enum logic [1:0] {RA_MGMT, RA_DROP, RA_FLOOD, RA_FLOOD_NM} res_act_t;

   typedef struct packed {
      logic [47:0] da;
      logic [47:0] sa;
      logic [FID_W-1:0] filter_group_id;
      logic [PW-1:0] src;
      logic [LEN_W-1:0] len;
      logic err;
   } rx_req_t;

   typedef struct packed {
      logic valid;
      logic stat;
      logic [47:0] mac;
      logic [FID_W-1:0] filter_group_id;
      logic [NPORT-1:0] mask;
      logic [STAMP_W-1:0] stamp;
   } entry_t;

   typedef struct packed {
      logic valid;
      logic [47:0] mac;
      logic [FID_W-1:0] filter_group_id;
      logic [NPORT-1:0] mask;
   } stat_ent_t;

   // reserved multicast group of the last address byte: {hit, action}
   function automatic logic [2:0] res_group(input logic [7:0] lo);
      logic [2:0] r;
      r = {1'b1, RA_FLOOD_NM};
      if (lo == 8'h00 || lo == 8'h03 || lo == 8'h02 || (lo >= 8'h04 && lo <= 8'h0f))
         r = {1'b1, RA_MGMT};
      else if (lo == 8'h01)
         r = {1'b1, RA_DROP};
      else if (lo == 8'h10)
         r = {1'b1, RA_FLOOD};
      else if (lo > 8'h2f)
         r = 3'h0;
      return r;
   endfunction : res_group
endpackage : lookup_pkg

// *** hw/lookup_hash.sv ***
`timescale 1ns/100ps
// index generator for the main table, purely combinational
module lookup_hash (
   input wire logic [47:0] mac_i,
   input wire logic [lookup_pkg::FID_W-1:0] fid_i,
   input wire logic [1:0] sel_i,
   output logic [lookup_pkg::IDX_W-1:0] idx_o
);
   // msb first over address then group id, shift register form
   function automatic logic [15:0] crc16(input logic [54:0] d);
      logic [15:0] c;
      logic fb;
      c = lookup_pkg::CRC_INIT;
      for (int i = 54; i >= 0; i--) begin
         fb = c[15] ^ d[i];
         c = {c[14:0], 1'b0} ^ (fb ? lookup_pkg::CRC_POLY : 16'h0000);
      end
      return c;
   endfunction : crc16

   logic [15:0] crc_w;
   logic [15:0] fold_w;
   logic [lookup_pkg::IDX_W-1:0] base_w;
   logic [lookup_pkg::IDX_W-1:0] fid_ext_w;

   assign crc_w = crc16({mac_i, fid_i});
   assign fold_w = mac_i[47:32] ^ mac_i[31:16] ^ mac_i[15:0];
   assign fid_ext_w = {3'h0, fid_i};

   // sum wraps modulo the bucket count on purpose
   always_comb begin
      if (sel_i == lookup_pkg::HASH_CRC)
         base_w = crc_w[9:0];
      else if (sel_i == lookup_pkg::HASH_XOR)
         base_w = fold_w[9:0];
      else
         base_w = mac_i[9:0];
      idx_o = base_w + fid_ext_w;
   end
endmodule : lookup_hash

// *** hw/lookup_static_table.sv ***
`timescale 1ns/100ps
// small software-filled table, searched in parallel
module lookup_static_table (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic wr_i,
   input wire logic [3:0] wr_idx_i,
   input wire lookup_pkg::stat_ent_t wr_ent_i,
   input wire logic [47:0] mac_i,
   input wire logic [lookup_pkg::FID_W-1:0] fid_i,
   output logic hit_o,
   output logic [lookup_pkg::NPORT-1:0] mask_o
);
   lookup_pkg::stat_ent_t tbl_r [lookup_pkg::NSTAT];
   logic [lookup_pkg::NSTAT-1:0] hit_w;

   // only the register port writes here, any address type is stored
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < lookup_pkg::NSTAT; i++)
            tbl_r[i].valid <= 1'b0;
      end else if (ce_i && wr_i) begin
         tbl_r[wr_idx_i] <= wr_ent_i;
      end
   end

   genvar g;
   generate
      for (g = 0; g < lookup_pkg::NSTAT; g++) begin : g_cmp
         assign hit_w[g] = tbl_r[g].valid && tbl_r[g].mac == mac_i && tbl_r[g].filter_group_id == fid_i;
      end
   endgenerate

   // lowest slot wins when software stored duplicates
   always_comb begin
      hit_o = 1'b0;
      mask_o = '0;
      for (int i = lookup_pkg::NSTAT - 1; i >= 0; i--) begin
         if (hit_w[i]) begin
            hit_o = 1'b1;
            mask_o = tbl_r[i].mask;
         end
      end
   end
endmodule : lookup_static_table

// *** hw/mac_address_lookup_engine.sv ***
// The register offsets and the Wishbone register port were chosen for this implementation.
`timescale 1ns/100ps
// How it works
// - a frame is decided only once it sits wholly in the buffer
// - one 256 KB pool is shared by all ports, reserved per frame
// - only one tail-tag port is host; it takes management traffic
// - good frames with a known destination go to the stored port
// - destination searched in main, static and reserved multicast tables
// - main table is 1K buckets of four ways, 10-bit hashed index
// - all four ways of a bucket are compared at once
// - hardware learns dynamic entries; static ones come from software only
// - vlan aware mode hashes the frame's group id with the address
// - vlan unaware mode hashes with group id zero
// - mode 01 (reset) uses CRC-CCITT bits 9:0
// - the hash bits are added to the zero-extended group id
// - mode 10 xors three 16-bit address folds
// - modes 00 and 11 use the ten low address bits
// - static table is software-filled, any address, same as main static
// - frames sourced from the switch address are dropped where enabled
// - static hits win over dynamic hits
// - learning evicts the oldest dynamic way, never a static one
module mac_address_lookup_engine (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic rx_valid_i,
   input wire lookup_pkg::rx_req_t rx_req_i,
   output logic rx_ready_o,
   input wire logic buf_release_i,
   input wire logic [lookup_pkg::LEN_W-1:0] buf_release_len_i,
   output logic fwd_valid_o,
   output logic [lookup_pkg::NPORT-1:0] fwd_mask_o,
   output logic fwd_drop_o
);
   typedef enum logic [1:0] {ST_IDLE, ST_LOOK, ST_LEARN, ST_SWWR} state_t;

   state_t state_r;
   lookup_pkg::rx_req_t req_r;
   lookup_pkg::entry_t tbl_r [lookup_pkg::NBUCKET][lookup_pkg::NWAY];
   logic [31:0] ctrl0_r;
   logic [31:0] ctrl1_r;
   logic [47:0] swmac_r;
   logic [47:0] tmac_r;
   logic [31:0] tattr_r;
   logic main_pend_r;
   logic stat_wr_r;
   logic room_r;
   logic [lookup_pkg::FREE_W-1:0] free_r;
   logic [lookup_pkg::STAMP_W-1:0] stamp_r;
   logic full_r;
   logic [lookup_pkg::IDX_W-1:0] full_idx_r;

   // byte-lane merge for every writable register
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++)
         if (sel[i])
            r[i*8 +: 8] = nw[i*8 +: 8];
      return r;
   endfunction : merge

   function automatic logic [lookup_pkg::NPORT-1:0] onehot(input logic [lookup_pkg::PW-1:0] p);
      return lookup_pkg::NPORT'(1) << p;
   endfunction : onehot

   // ---------------- register bus ----------------
   logic wb_req_w;
   logic wb_wr_w;
   logic [2:0] tail_w;
   logic [1:0] hash_sel_w;
   logic vlan_aware_enable;
   logic [lookup_pkg::NPORT-1:0] self_en_w;

   assign wb_req_w = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wb_wr_w = wb_req_w && wb_we_i;
   assign vlan_aware_enable = ctrl0_r[lookup_pkg::C0_VLAN];
   assign hash_sel_w = ctrl0_r[lookup_pkg::C0_HASH +: 2];
   assign self_en_w = ctrl1_r[lookup_pkg::C1_SELF +: lookup_pkg::NPORT];
   assign tail_w = ctrl1_r[lookup_pkg::C1_TAIL +: lookup_pkg::NPORT];

   // one wait-free cycle: ack the cycle after the strobe, drop it next
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
      end else if (ce_i) begin
         wb_ack_o <= wb_req_w;
         wb_dat_o <= 32'h0; // unmapped offsets read zero
         if (wb_req_w && !wb_we_i) begin
            case (wb_adr_i)
               lookup_pkg::OFS_CTRL0: wb_dat_o <= ctrl0_r;
               lookup_pkg::OFS_CTRL1: wb_dat_o <= ctrl1_r;
               lookup_pkg::OFS_SWMAC_LO: wb_dat_o <= swmac_r[31:0];
               lookup_pkg::OFS_SWMAC_HI: wb_dat_o <= {16'h0, swmac_r[47:32]};
               lookup_pkg::OFS_TMAC_LO: wb_dat_o <= tmac_r[31:0];
               lookup_pkg::OFS_TMAC_HI: wb_dat_o <= {16'h0, tmac_r[47:32]};
               lookup_pkg::OFS_TATTR: wb_dat_o <= tattr_r;
               lookup_pkg::OFS_TCMD: wb_dat_o <= {31'h0, main_pend_r};
               lookup_pkg::OFS_STATUS: wb_dat_o <= {13'h0, free_r};
               lookup_pkg::OFS_FULL: wb_dat_o <= {15'h0, full_r, 6'h0, full_idx_r};
               default: wb_dat_o <= 32'h0;
            endcase
         end
      end
   end

   // configuration registers; reserved bits are masked off
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl0_r <= {29'h0, lookup_pkg::HASH_RST, 1'b0};
         ctrl1_r <= 32'h0;
         swmac_r <= 48'h0;
         tmac_r <= 48'h0;
         tattr_r <= 32'h0;
      end else if (ce_i && wb_wr_w) begin
         case (wb_adr_i)
            lookup_pkg::OFS_CTRL0: ctrl0_r <= merge(ctrl0_r, wb_dat_i, wb_sel_i) & 32'hf;
            lookup_pkg::OFS_CTRL1: ctrl1_r <= merge(ctrl1_r, wb_dat_i, wb_sel_i) & 32'h77;
            lookup_pkg::OFS_SWMAC_LO: swmac_r[31:0] <= merge(swmac_r[31:0], wb_dat_i, wb_sel_i);
            lookup_pkg::OFS_SWMAC_HI:
               swmac_r[47:32] <= 16'(merge({16'h0, swmac_r[47:32]}, wb_dat_i, wb_sel_i));
            lookup_pkg::OFS_TMAC_LO: tmac_r[31:0] <= merge(tmac_r[31:0], wb_dat_i, wb_sel_i);
            lookup_pkg::OFS_TMAC_HI:
               tmac_r[47:32] <= 16'(merge({16'h0, tmac_r[47:32]}, wb_dat_i, wb_sel_i));
            lookup_pkg::OFS_TATTR: tattr_r <= merge(tattr_r, wb_dat_i, wb_sel_i) & 32'hf107f7;
            default: ;
         endcase
      end
   end

   // table commands: static slot write is immediate, main write waits for idle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         stat_wr_r <= 1'b0;
         main_pend_r <= 1'b0;
      end else if (ce_i) begin
         stat_wr_r <= wb_wr_w && wb_adr_i == lookup_pkg::OFS_TCMD && wb_sel_i[0]
                      && wb_dat_i[lookup_pkg::CMD_STAT];
         if (wb_wr_w && wb_adr_i == lookup_pkg::OFS_TCMD && wb_sel_i[0]
             && wb_dat_i[lookup_pkg::CMD_MAIN])
            main_pend_r <= 1'b1;
         else if (state_r == ST_SWWR)
            main_pend_r <= 1'b0;
      end
   end

   // ---------------- hashing and bucket compare ----------------
   logic [47:0] hmac_w;
   logic [lookup_pkg::FID_W-1:0] hfid_w;
   logic [lookup_pkg::IDX_W-1:0] idx_w;
   logic [lookup_pkg::FID_W-1:0] tfid_w;
   lookup_pkg::entry_t bkt_w [lookup_pkg::NWAY];
   logic [lookup_pkg::NWAY-1:0] hit_w;

   assign tfid_w = tattr_r[lookup_pkg::TA_FID +: lookup_pkg::FID_W];

   // one hash unit shared by lookup, learning and software writes
   always_comb begin
      hmac_w = req_r.da;
      hfid_w = vlan_aware_enable ? req_r.filter_group_id : lookup_pkg::FID_DEFAULT;
      if (state_r == ST_LEARN)
         hmac_w = req_r.sa;
      else if (state_r == ST_SWWR) begin
         hmac_w = tmac_r;
         hfid_w = vlan_aware_enable ? tfid_w : lookup_pkg::FID_DEFAULT;
      end
   end

   lookup_hash u_hash (
      .mac_i(hmac_w),
      .fid_i(hfid_w),
      .sel_i(hash_sel_w),
      .idx_o(idx_w)
   );

   genvar g;
   generate
      for (g = 0; g < lookup_pkg::NWAY; g++) begin : g_way
         assign bkt_w[g] = tbl_r[idx_w][g];
         assign hit_w[g] = bkt_w[g].valid && bkt_w[g].mac == hmac_w
                           && bkt_w[g].filter_group_id == hfid_w;
      end
   endgenerate

   // victim: matching way, else a free way, else the oldest dynamic way
   logic vic_ok_w;
   logic [1:0] vic_w;
   logic hit_any_w;
   logic hit_stat_w;
   logic [lookup_pkg::NPORT-1:0] hit_mask_w;
   logic [lookup_pkg::STAMP_W-1:0] age_w;
   logic [lookup_pkg::STAMP_W-1:0] best_age_w;
   logic free_ok_w;

   always_comb begin
      vic_ok_w = 1'b0;
      vic_w = 2'h0;
      hit_any_w = 1'b0;
      hit_stat_w = 1'b0;
      hit_mask_w = '0;
      best_age_w = '0;
      free_ok_w = 1'b0;
      age_w = '0;
      for (int w = lookup_pkg::NWAY - 1; w >= 0; w--) begin
         if (hit_w[w]) begin
            hit_any_w = 1'b1;
            hit_stat_w = bkt_w[w].stat;
            hit_mask_w = bkt_w[w].mask;
         end
      end
      for (int w = 0; w < lookup_pkg::NWAY; w++) begin
         age_w = stamp_r - bkt_w[w].stamp;
         if (!bkt_w[w].valid && !free_ok_w) begin
            free_ok_w = 1'b1;
            vic_ok_w = 1'b1;
            vic_w = 2'(w);
         end else if (!free_ok_w && !bkt_w[w].stat && (!vic_ok_w || age_w > best_age_w)) begin
            vic_ok_w = 1'b1;
            vic_w = 2'(w);
            best_age_w = age_w;
         end
      end
      for (int w = 0; w < lookup_pkg::NWAY; w++)
         if (hit_w[w]) begin
            vic_ok_w = 1'b1;
            vic_w = 2'(w);
         end
   end

   // ---------------- forwarding decision ----------------
   logic st_hit_w;
   logic [lookup_pkg::NPORT-1:0] st_mask_w;
   logic [2:0] res_w;
   logic res_hit_w;
   logic [lookup_pkg::NPORT-1:0] host_w;
   logic [lookup_pkg::NPORT-1:0] res_mask_w;
   logic [lookup_pkg::NPORT-1:0] dec_mask_w;
   logic drop_w;
   lookup_pkg::stat_ent_t sent_w;

   assign sent_w = '{valid: tattr_r[lookup_pkg::TA_VALID], mac: tmac_r, filter_group_id: tfid_w,
                     mask: tattr_r[lookup_pkg::TA_MASK +: lookup_pkg::NPORT]};

   lookup_static_table u_static (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .wr_i(stat_wr_r),
      .wr_idx_i(tattr_r[lookup_pkg::TA_SIDX +: 4]),
      .wr_ent_i(sent_w),
      .mac_i(req_r.da),
      .fid_i(hfid_w),
      .hit_o(st_hit_w),
      .mask_o(st_mask_w)
   );

   // the lowest tail-tag port is host, so a second one never takes the role
   always_comb begin
      host_w = onehot(lookup_pkg::MGMT_DFL_PORT);
      for (int p = lookup_pkg::NPORT - 1; p >= 0; p--)
         if (tail_w[p])
            host_w = onehot(lookup_pkg::PW'(p));
   end

   assign res_w = lookup_pkg::res_group(req_r.da[7:0]);
   assign res_hit_w = ctrl0_r[lookup_pkg::C0_RESMC] && res_w[2]
                      && req_r.da[47:8] == lookup_pkg::RES_PREFIX;

   always_comb begin
      case (lookup_pkg::res_act_t'(res_w[1:0]))
         lookup_pkg::RA_MGMT: res_mask_w = host_w;
         lookup_pkg::RA_DROP: res_mask_w = '0;
         lookup_pkg::RA_FLOOD: res_mask_w = '1;
         lookup_pkg::RA_FLOOD_NM: res_mask_w = ~host_w;
         default: res_mask_w = '0;
      endcase
   end

   // static table first, then reserved groups, then main table, then flood
   always_comb begin
      if (st_hit_w)
         dec_mask_w = st_mask_w;
      else if (res_hit_w)
         dec_mask_w = res_mask_w;
      else if (hit_any_w)
         dec_mask_w = hit_mask_w;
      else
         dec_mask_w = '1;
      dec_mask_w = dec_mask_w & ~onehot(req_r.src);
      drop_w = req_r.err || !room_r
               || (self_en_w[req_r.src] && req_r.sa == swmac_r);
   end

   // ---------------- sequencing ----------------
   assign rx_ready_o = ce_i && state_r == ST_IDLE && !main_pend_r;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_r <= ST_IDLE;
         req_r <= '0;
      end else if (ce_i) begin
         case (state_r)
            ST_IDLE: begin
               if (main_pend_r)
                  state_r <= ST_SWWR;
               else if (rx_valid_i) begin
                  req_r <= rx_req_i;
                  state_r <= ST_LOOK;
               end
            end
            ST_LOOK: state_r <= drop_w ? ST_IDLE : ST_LEARN;
            ST_LEARN: state_r <= ST_IDLE;
            ST_SWWR: state_r <= ST_IDLE;
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   // decision output, one pulse per accepted frame
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fwd_valid_o <= 1'b0;
         fwd_mask_o <= '0;
         fwd_drop_o <= 1'b0;
      end else if (ce_i) begin
         fwd_valid_o <= state_r == ST_LOOK;
         if (state_r == ST_LOOK) begin
            fwd_drop_o <= drop_w;
            fwd_mask_o <= drop_w ? '0 : dec_mask_w;
         end
      end
   end

   // shared pool: a frame holds its bytes until the buffer side releases them
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         free_r <= lookup_pkg::FREE_W'(lookup_pkg::BUF_BYTES);
         room_r <= 1'b0;
      end else if (ce_i) begin
         if (rx_ready_o && rx_valid_i) begin
            room_r <= !rx_req_i.err && free_r >= lookup_pkg::FREE_W'(rx_req_i.len);
            free_r <= free_r + (buf_release_i ? lookup_pkg::FREE_W'(buf_release_len_i) : '0)
                      - ((!rx_req_i.err && free_r >= lookup_pkg::FREE_W'(rx_req_i.len))
                         ? lookup_pkg::FREE_W'(rx_req_i.len) : '0);
         end else if (buf_release_i)
            free_r <= free_r + lookup_pkg::FREE_W'(buf_release_len_i);
      end
   end

   // main table writes: learning, migration, refresh and software statics
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int b = 0; b < lookup_pkg::NBUCKET; b++)
            for (int w = 0; w < lookup_pkg::NWAY; w++)
               tbl_r[b][w].valid <= 1'b0;
         stamp_r <= '0;
         full_r <= 1'b0;
         full_idx_r <= '0;
      end else if (ce_i) begin
         if (state_r == ST_LEARN && !req_r.sa[40] && !(hit_any_w && hit_stat_w)) begin
            if (vic_ok_w) begin
               tbl_r[idx_w][vic_w] <= '{valid: 1'b1, stat: 1'b0, mac: req_r.sa, filter_group_id: hfid_w,
                                        mask: onehot(req_r.src), stamp: stamp_r};
               stamp_r <= stamp_r + lookup_pkg::STAMP_W'(1);
            end else begin
               full_r <= 1'b1;
               full_idx_r <= idx_w;
            end
         end else if (state_r == ST_SWWR) begin
            if (vic_ok_w)
               tbl_r[idx_w][vic_w] <= '{valid: sent_w.valid, stat: 1'b1, mac: tmac_r,
                                        filter_group_id: hfid_w, mask: sent_w.mask, stamp: stamp_r};
            else begin
               full_r <= 1'b1;
               full_idx_r <= idx_w;
            end
         end
      end
   end
endmodule : mac_address_lookup_engine

// *** tb/mac_address_lookup_engine_assertions.sv ***
`timescale 1ns/100ps
// watches the top ports only
module lookup_checker (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic [31:0] wb_dat_o,
   input wire logic rx_valid_i,
   input wire lookup_pkg::rx_req_t rx_req_i,
   input wire logic rx_ready_o,
   input wire logic fwd_valid_o,
   input wire logic [2:0] fwd_mask_o,
   input wire logic fwd_drop_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic take;
   // a request is taken on an edge where both sides agree
   assign take = rx_valid_i && rx_ready_o;
   wb_ack_due_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |=> wb_ack_o)
      else $error("ack missing");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
   fwd_time_a: assert property (take |=> ##1 fwd_valid_o) else $error("no decision");
   busy_refuse_a: assert property (take |=> !rx_ready_o) else $error("ready while busy");
   fwd_pulse_a: assert property (fwd_valid_o |=> !fwd_valid_o) else $error("decision held");
   err_drop_a: assert property (take && rx_req_i.err |=> ##1 fwd_drop_o && fwd_mask_o == 3'h0)
      else $error("error frame kept");
   src_clear_a: assert property (fwd_valid_o |-> fwd_mask_o[$past(rx_req_i.src, 2)] == 1'b0)
      else $error("sent back to source");
   no_spurious_a: assert property (fwd_valid_o |-> $past(take, 2)) else $error("stray decision");
   rst_quiet_a: assert property ($fell(rst_i) |-> !fwd_valid_o && !wb_ack_o)
      else $error("busy after reset");
endmodule : lookup_checker

bind mac_address_lookup_engine lookup_checker i_lookup_checker (.clk_i(clk_i), .rst_i(rst_i),
   .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
   .wb_dat_o(wb_dat_o), .rx_valid_i(rx_valid_i), .rx_req_i(rx_req_i), .rx_ready_o(rx_ready_o),
   .fwd_valid_o(fwd_valid_o), .fwd_mask_o(fwd_mask_o), .fwd_drop_o(fwd_drop_o));

// *** tb/rx_source_model.sv ***
`timescale 1ns/100ps
// receive side stand-in: offers one parsed frame and holds it until taken
module rx_source_model (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic start_i,
   input wire lookup_pkg::rx_req_t req_i,
   input wire logic rx_ready_i,
   output logic rx_valid_o,
   output lookup_pkg::rx_req_t rx_req_o
);
   // outside a request the fields toggle so stale values are never trusted
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rx_valid_o <= 1'b0;
         rx_req_o <= '0;
      end else if (start_i) begin
         rx_valid_o <= 1'b1;
         rx_req_o <= req_i;
      end else if (!rx_valid_o || rx_ready_i) begin
         rx_valid_o <= 1'b0;
         rx_req_o <= ~rx_req_o;
      end
   end
endmodule : rx_source_model

// *** tb/mac_address_lookup_engine_tb.sv ***
`timescale 1ns/100ps
module mac_address_lookup_engine_tb;
   logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0, start = 1'b0, rel = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0, rdat, q, x;
   logic [13:0] rel_len = 14'h0;
   lookup_pkg::rx_req_t rq = '0, rx_req;
   logic rx_valid, rx_ready, ack, fv, fd;
   logic [2:0] fm;
   int failures = 0, total_checks = 0;
   // 20 MHz clock
   initial forever #25 clk_i = ~clk_i;
   mac_address_lookup_engine i_mac_address_lookup_engine (.clk_i(clk_i), .rst_i(rst_i),
      .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .rx_valid_i(rx_valid),
      .rx_req_i(rx_req), .rx_ready_o(rx_ready), .buf_release_i(rel), .buf_release_len_i(rel_len),
      .fwd_valid_o(fv), .fwd_mask_o(fm), .fwd_drop_o(fd));
   rx_source_model i_rx_source_model (.clk_i(clk_i), .rst_i(rst_i), .start_i(start),
      .req_i(rq), .rx_ready_i(rx_ready), .rx_valid_o(rx_valid), .rx_req_o(rx_req));
   task chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // one classic cycle, held until ack is seen, then one idle cycle
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do @(posedge clk_i); while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
      @(posedge clk_i);
   endtask : wb
   task send(input lookup_pkg::rx_req_t r, input logic [2:0] m, input logic d);
      start <= 1'b1;
      rq <= r;
      @(posedge clk_i);
      start <= 1'b0;
      do @(posedge clk_i); while (fv !== 1'b1);
      chk(fm, m);
      chk(fd, d);
      repeat (3) @(posedge clk_i);
   endtask : send
   // table write; the pending flag is polled since the write may be deferred
   task tw(input logic [47:0] a, input logic [6:0] f, input logic [2:0] m, input logic [1:0] c);
      wb(1'b1, lookup_pkg::OFS_TMAC_LO, a[31:0]);
      wb(1'b1, lookup_pkg::OFS_TMAC_HI, {16'h0, a[47:32]});
      wb(1'b1, lookup_pkg::OFS_TATTR, {15'h0, 1'b1, 5'h0, f, 1'b0, m});
      wb(1'b1, lookup_pkg::OFS_TCMD, {30'h0, c});
      do wb(1'b0, lookup_pkg::OFS_TCMD, 32'h0); while (q[0] !== 1'b0);
   endtask : tw
   function automatic logic [47:0] mac(input logic v, input logic [7:0] k);
      return v ? {24'h0, k, 8'h0, k} : {8'h0, k, 32'h0000_0123};
   endfunction : mac
   function automatic logic [9:0] idx(input logic v, input logic [6:0] f);
      return (v ? 10'h000 : 10'h123) + {3'h0, f};
   endfunction : idx
   task report_and_stop;
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : report_and_stop
   // watchdog
   initial begin
      repeat (20000) @(posedge clk_i);
      failures++;
      report_and_stop;
   end
   initial begin
      x = $urandom(25182);
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b0, lookup_pkg::OFS_CTRL0, 32'h0);
      chk(q, 32'h2);
      wb(1'b0, 8'h30, 32'h0);
      chk(q, 32'h0);
      send('{48'h0200_0000_0a01, 48'h0002_1111_2222, 7'h0, 2'h1, 14'h40, 1'b0}, 3'h5, 1'b0);
      wb(1'b0, lookup_pkg::OFS_STATUS, 32'h0);
      chk(q, 32'h0003_ffc0);
      rel <= 1'b1;
      rel_len <= 14'h40;
      @(posedge clk_i);
      rel <= 1'b0;
      wb(1'b0, lookup_pkg::OFS_STATUS, 32'h0);
      chk(q, 32'h0004_0000);
      send('{48'h0002_1111_2222, 48'h0004_0000_0001, 7'h0, 2'h0, 14'h40, 1'b0}, 3'h2, 1'b0);
      tw(48'h0002_1111_2222, 7'h0, 3'h4, 2'h1);
      send('{48'h0002_1111_2222, 48'h0004_0000_0001, 7'h0, 2'h2, 14'h40, 1'b0}, 3'h0, 1'b0);
      send('{48'h0002_1111_2222, 48'h0004_0000_0001, 7'h0, 2'h0, 14'h40, 1'b0}, 3'h4, 1'b0);
      send('{48'h0002_1111_2222, 48'h0004_0000_0001, 7'h0, 2'h0, 14'h40, 1'b1}, 3'h0, 1'b1);
      wb(1'b1, lookup_pkg::OFS_SWMAC_LO, x);
      wb(1'b1, lookup_pkg::OFS_SWMAC_HI, 32'h0000_0006);
      wb(1'b1, lookup_pkg::OFS_CTRL1, 32'h1);
      send('{48'h0002_1111_2222, {16'h6, x}, 7'h0, 2'h0, 14'h40, 1'b0}, 3'h0, 1'b1);
      // reserved groups on, tail tag on port 1 makes it the host
      wb(1'b1, lookup_pkg::OFS_CTRL1, 32'h21);
      wb(1'b1, lookup_pkg::OFS_CTRL0, 32'ha);
      send('{48'h0180_c200_0000, 48'h0004_0000_0001, 7'h0, 2'h0, 14'h40, 1'b0}, 3'h2, 1'b0);
      send('{48'h0180_c200_0001, 48'h0004_0000_0001, 7'h0, 2'h2, 14'h40, 1'b0}, 3'h0, 1'b0);
      for (int i = 0; i < 6; i++) begin
         x = $urandom_range(2);
         send('{{8'h02, 8'h77, 32'($urandom)}, {8'h08, 40'($urandom)}, 7'h0, x[1:0],
            14'($urandom_range(1518, 64)), 1'b0}, 3'h7 & ~(3'h1 << x[1:0]), 1'b0);
      end
      // for hash modes 00 and 10: fill one bucket with statics, then learn into it
      for (int v = 0; v < 2; v++) begin
         rst_i <= 1'b1;
         repeat (3) @(posedge clk_i);
         rst_i <= 1'b0;
         wb(1'b1, lookup_pkg::OFS_CTRL0, v ? 32'h5 : 32'h0);
         for (int k = 1; k < 5; k++)
            tw(mac(v, 8'(k)), v ? 7'h5 : 7'h0, 3'h1, 2'h2);
         send('{48'h0200_0000_0077, mac(v, 8'h5), 7'h5, 2'h0, 14'h40, 1'b0}, 3'h6, 1'b0);
         wb(1'b0, lookup_pkg::OFS_FULL, 32'h0);
         chk(q, {15'h0, 1'b1, 6'h0, idx(v, v ? 7'h5 : 7'h0)});
         send('{mac(v, 8'h1), 48'h0004_0000_0009, 7'h5, 2'h2, 14'h40, 1'b0}, 3'h1, 1'b0);
      end
      report_and_stop;
   end
endmodule : mac_address_lookup_engine_tb
